// File: common/cps_pkg.sv
package cps_pkg;
  // ----------
  // Clock and execution times
  // ----------
  localparam int CLK_NS = 10;
  function automatic int cps_cycles(input int t_ns);
    return (t_ns + CLK_NS - 1) / CLK_NS;
  endfunction : cps_cycles
  localparam int T_BASIC_NS = 750;
  localparam int T_TAKEN_NS = 2000;
  localparam int T_ADDC_NS = 3250;
  localparam int T_ADDC_B_NS = 3400;
  localparam int T_ADDC_IMO_NS = 3200;
  localparam int T_BS_NS = 3750;
  localparam int T_RETURN_FROM_SUBROUTINE_NS = 1500;
  localparam int T_ROT_NS = 1300;
  localparam int T_QFULL_NS = 1100;
  localparam int T_QUEUE_NS = 1200;
  localparam int T_TLU_HIT_NS = 6000;
  localparam int T_TLU_SRCH_NS = 7500;
  localparam int T_RETU_NS = 2500;
  localparam int T_ADDRESS_RANGE_COMPARE_NS = 6750;
  localparam int T_CCH_NS = 3900;
  localparam int T_LD_EXT_NS = 6100;
  localparam int T_ST_EXT_NS = 6800;
  localparam int T_SEND0_NS = 5800;
  localparam int T_SEND1_NS = 10900;
  localparam int T_SEND2_NS = 7900;
  localparam int T_SEND3_NS = 12900;
  localparam int T_RECV0_NS = 5400;
  localparam int T_RECV1_NS = 11100;
  localparam int T_RECV2_NS = 8500;
  localparam int T_RECV3_NS = 13800;
  localparam int TIMER_W = 11;
  // ----------
  // Instruction word: class, mode, operand
  // ----------
  typedef enum logic [4:0] {
    OP_ADD = 5'h00, OP_AND = 5'h01, OP_CMP = 5'h02, OP_ADDC = 5'h03,
    OP_CLR = 5'h04, OP_LD = 5'h05, OP_ST = 5'h06, OP_ROTR = 5'h07,
    OP_BCT = 5'h08, OP_BZT = 5'h09, OP_BS = 5'h0A, OP_RETURN_FROM_SUBROUTINE = 5'h0B,
    OP_SEND = 5'h0C, OP_RECEIVE_CHAR = 5'h0D, OP_QFULL = 5'h0E, OP_DEQ = 5'h0F,
    OP_ENQ = 5'h10, OP_TLU = 5'h11, OP_RETU = 5'h12, OP_ADDRESS_RANGE_COMPARE = 5'h13,
    OP_CCH = 5'h14, OP_HALT = 5'h15
  } cps_class_t;
  localparam logic [2:0] M_R_LCT = 3'h0;
  localparam logic [2:0] M_B_LCT = 3'h1;
  localparam logic [2:0] M_R_IND = 3'h2;
  localparam logic [2:0] M_R_IMO = 3'h3;
  localparam logic [2:0] M_B_IMO = 3'h4;
  localparam logic [2:0] M_R_EXT = 3'h5;
  localparam logic [2:0] M_B_FROM_R = 3'h6;
  localparam logic [2:0] M_R_FROM_B = 3'h7;
  // ----------
  // Fixed control table bytes and operation constants
  // ----------
  localparam logic [5:0] CT_RETURN = 6'h12;
  localparam logic [5:0] CT_FLAGS = 6'h13;
  localparam logic [5:0] CT_QHEAD = 6'h14;
  localparam logic [5:0] CT_QTAIL = 6'h15;
  localparam logic [5:0] CT_STACK = 6'h16;
  localparam logic [5:0] CT_CUR_ADDR = 6'h18;
  localparam logic [5:0] CT_CUR_RANGE = 6'h19;
  localparam logic [5:0] CT_INIT_ADDR = 6'h1A;
  localparam logic [5:0] CT_INIT_RANGE = 6'h1B;
  localparam logic [7:0] QFULL_BIAS = 8'h0F;
  localparam logic [7:0] MSB_WEIGHT = 8'h80;
  localparam logic [7:0] TLU_MASK = 8'h7F;
  localparam logic [7:0] TLU_SKIP = 8'h02;
  localparam logic [7:0] TLU_BIAS = 8'h03;
  localparam logic [7:0] CRC_POLY = 8'h07;
endpackage : cps_pkg

// File: dv/cps_line_model.sv
// ----------
// Line adapter model
// ----------
module cps_line_model (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_stall,
  input wire logic [7:0] i_rx_value,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_ready,
  output logic [7:0] o_line_rx
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got[$];
  logic pace;
  // Line register value seen by receive
  assign o_line_rx = i_rx_value;
  // Slow consumer, ready every other cycle
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pace <= 1'b0;
    end else begin
      pace <= ~pace;
    end
  end
  assign o_tx_ready = pace && !i_stall;
  // Collect each accepted byte
  always @(posedge i_clock) begin
    if (i_rst_b && i_tx_valid && o_tx_ready) begin
      got.push_back(i_tx_data);
    end
  end
endmodule : cps_line_model

// File: dv/cps_sequencer_bench.sv
module cps_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------
  // Signals and instances
  // ----------
  logic i_clock = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_prog_we = 1'b0;
  logic [7:0] i_prog_addr = 8'h00;
  logic [15:0] i_prog_data = 16'h0000;
  logic i_start = 1'b0;
  logic [1:0] i_channel = 2'h0;
  logic stall = 1'b0;
  logic [7:0] rx_value = 8'h00;
  logic [7:0] line_rx, o_tx_data, o_pc, o_acc, o_ptr, o_work;
  logic tx_ready, o_tx_valid, o_busy, o_done, o_carry, o_zero, o_rx_parity_err;
  int fails = 0;
  int compares = 0;
  int ticks = 0;
  int cyc;
  cps_sequencer u_dut (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_prog_we(i_prog_we),
    .i_prog_addr(i_prog_addr),
    .i_prog_data(i_prog_data),
    .i_start(i_start),
    .i_channel(i_channel),
    .i_line_rx(line_rx),
    .i_tx_ready(tx_ready),
    .o_tx_valid(o_tx_valid),
    .o_tx_data(o_tx_data),
    .o_busy(o_busy),
    .o_done(o_done),
    .o_pc(o_pc),
    .o_acc(o_acc),
    .o_ptr(o_ptr),
    .o_work(o_work),
    .o_carry(o_carry),
    .o_zero(o_zero),
    .o_rx_parity_err(o_rx_parity_err)
  );
  cps_line_model u_line (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_stall(stall),
    .i_rx_value(rx_value),
    .i_tx_valid(o_tx_valid),
    .i_tx_data(o_tx_data),
    .o_tx_ready(tx_ready),
    .o_line_rx(line_rx)
  );
  initial begin
    forever #5 i_clock = ~i_clock;
  end
  // ----------
  // Run control and compares
  // ----------
  task automatic finish_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test
  always @(posedge i_clock) begin
    ticks++;
    if (ticks == 90000) begin
      fails++;
      finish_test();
    end
  end
  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h got %h", what, exp, got);
    end
  endtask : cmp8
  task automatic cmp_int(input string what, input int exp, input int got);
    compares++;
    if (got != exp) begin
      fails++;
      $display("BAD %s expected %0d got %0d", what, exp, got);
    end
  endtask : cmp_int
  task automatic launch(input logic [15:0] p[$], input logic [1:0] ch);
    foreach (p[k]) begin
      @(posedge i_clock);
      i_prog_we <= 1'b1;
      i_prog_addr <= 8'(k);
      i_prog_data <= p[k];
    end
    @(posedge i_clock);
    i_prog_we <= 1'b0;
    i_channel <= ch;
    i_start <= 1'b1;
    @(posedge i_clock);
    i_start <= 1'b0;
  endtask : launch
  task automatic wait_done();
    cyc = 0;
    while (o_done !== 1'b1 && cyc < 20000) begin
      @(posedge i_clock);
      #1;
      cyc++;
    end
    cmp8("done", 8'h01, {7'h00, o_done});
  endtask : wait_done
  task automatic go(input logic [15:0] p[$], input logic [1:0] ch = 2'h0);
    launch(p, ch);
    wait_done();
  endtask : go
  task automatic wait_tx(input int n);
    repeat (4000) begin
      if (u_line.got.size() < n) begin
        @(posedge i_clock);
      end
    end
    cmp_int("tx count", n, u_line.got.size());
  endtask : wait_tx
  // ----------
  // Scenarios
  // ----------
  task automatic t_alu();
    go('{16'h2BF0, 16'h0320, 16'hA800});
    cmp8("add acc", 8'h10, o_acc);
    cmp8("add carry", 8'h01, {7'h00, o_carry});
    go('{16'h2BF0, 16'h0B0F, 16'hA800});
    cmp8("and zero", 8'h01, {7'h00, o_zero});
    go('{16'h2B35, 16'h1336, 16'hA800});
    cmp8("cmp acc", 8'h35, o_acc);
    cmp8("cmp carry", 8'h01, {7'h00, o_carry});
    go('{16'h2BFF, 16'h0301, 16'h1B05, 16'hA800});
    cmp8("addc acc", 8'h06, o_acc);
    go('{16'h2B77, 16'h2300, 16'hA800});
    cmp8("clear acc", 8'h00, o_acc);
    go('{16'h2BFF, 16'h0302, 16'h3800, 16'hA800});
    cmp8("rotate acc", 8'h80, o_acc);
    go('{16'h2C81, 16'h3C00, 16'hA800});
    cmp8("rotate ptr", 8'hC0, o_ptr);
  endtask : t_alu
  task automatic t_flow();
    go('{16'h2BFF, 16'h0301, 16'h4002, 16'h2B55, 16'h4802, 16'h2B66, 16'hA800});
    cmp8("taken acc", 8'h00, o_acc);
    go('{16'h2B00, 16'h0301, 16'h4003, 16'h0301, 16'h4802, 16'h0304, 16'hA800});
    cmp8("not taken acc", 8'h06, o_acc);
    go('{16'h5002, 16'hA800, 16'h2812, 16'h5800});
    cmp8("return byte", 8'h01, o_acc);
    go('{16'h2B30, 16'h3016, 16'h2B06, 16'h3031, 16'h9000, 16'h2B77, 16'hA800});
    cmp8("stack return", 8'h06, o_acc);
  endtask : t_flow
  task automatic t_tables();
    go('{16'h2B20, 16'h3014, 16'h3015, 16'h2B5A, 16'h8000, 16'h2B00, 16'h7800,
         16'h7000, 16'hA800});
    cmp8("dequeue acc", 8'h5A, o_acc);
    cmp8("queue full work", 8'hF1, o_work);
    go('{16'h2B11, 16'h3005, 16'hA800}, 2'h0);
    go('{16'h2B22, 16'h3005, 16'hA800}, 2'h1);
    go('{16'h2805, 16'hA800}, 2'h0);
    cmp8("channel byte", 8'h11, o_acc);
    go('{16'h2B00, 16'h3007, 16'h2C00, 16'h2B9C, 16'h3507, 16'hA800}, 2'h0);
    go('{16'h2B00, 16'h3007, 16'h2C00, 16'h2D07, 16'hA800}, 2'h1);
    cmp8("shared table", 8'h9C, o_acc);
    go('{16'h2B40, 16'h301A, 16'h2B03, 16'h301B, 16'h9800, 16'hA000, 16'h2819, 16'hA800});
    cmp8("compare work", 8'h00, o_work);
    cmp8("range step", 8'h04, o_acc);
  endtask : t_tables
  task automatic t_line();
    logic [7:0] rv[3] = '{8'h83, 8'h81, 8'h81};
    logic [15:0] op[3] = '{16'h6900, 16'h6800, 16'h6900};
    logic [7:0] ea[3] = '{8'h03, 8'h81, 8'h01};
    logic [7:0] es[4] = '{8'h07, 8'h87, 8'h07, 8'h87};
    logic [15:0] p[$];
    for (int k = 0; k < 3; k++) begin
      rx_value <= rv[k];
      go('{op[k], 16'hA800});
      cmp8("receive acc", ea[k], o_acc);
      if (op[k][8]) begin
        cmp8("parity error", {7'h00, ^rv[k]}, {7'h00, o_rx_parity_err});
      end
    end
    u_line.got.delete();
    go('{16'h2B07, 16'h6000, 16'h6100, 16'h6200, 16'h6300, 16'hA800});
    wait_tx(4);
    for (int k = 0; k < 4; k++) begin
      cmp8("send byte", es[k], u_line.got[k]);
    end
    for (int k = 0; k < 18; k++) begin
      p.push_back({8'h2B, 8'(k)});
      p.push_back(16'h6000);
    end
    p.push_back(16'hA800);
    u_line.got.delete();
    stall <= 1'b1;
    launch(p, 2'h0);
    repeat (12000) @(posedge i_clock);
    #1;
    cmp8("stalled busy", 8'h01, {7'h00, o_busy});
    @(posedge i_clock);
    stall <= 1'b0;
    wait_done();
    wait_tx(18);
    for (int k = 0; k < 18; k++) begin
      cmp8("fifo byte", 8'(k), u_line.got[k]);
    end
  endtask : t_line
  task automatic t_timing();
    logic [15:0] op[22] = '{16'h0320, 16'h0B0F, 16'h1336, 16'h1B01, 16'h1805, 16'h2300,
      16'h2D07, 16'h3507, 16'h3800, 16'h7000, 16'h7800, 16'h8000, 16'h9800, 16'hA000,
      16'h6000, 16'h6100, 16'h6200, 16'h6300, 16'h6800, 16'h6900, 16'h6A00, 16'h6B00};
    int n[22] = '{75, 75, 75, 320, 325, 75, 610, 680, 130, 110, 120, 120, 675, 390,
      580, 1090, 790, 1290, 540, 1110, 850, 1380};
    int c1;
    for (int k = 0; k < 22; k++) begin
      go('{op[k], 16'hA800});
      c1 = cyc;
      go('{op[k], op[k], 16'hA800});
      cmp_int("exec cycles", n[k] + 1, cyc - c1);
    end
  endtask : t_timing
  initial begin
    repeat (16) @(posedge i_clock);
    i_rst_b <= 1'b1;
    t_alu();
    t_flow();
    t_tables();
    t_line();
    t_timing();
    finish_test();
  end
endmodule : cps_sequencer_bench

// File: dv/cps_sequencer_chk.sv
// ----------
// Port checker
// ----------
module cps_sequencer_chk (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_start,
  input wire logic i_tx_ready,
  input wire logic o_tx_valid,
  input wire logic [7:0] o_tx_data,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic [7:0] o_pc,
  input wire logic [7:0] o_acc,
  input wire logic [7:0] o_ptr,
  input wire logic [7:0] o_work,
  input wire logic o_carry,
  input wire logic o_zero
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MIN_EXEC = 75;
  logic [7:0] pc_q;
  logic [11:0] held;
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_b);
  // Cycles since the program counter moved
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pc_q <= 8'h00;
    end else begin
      pc_q <= o_pc;
    end
  end
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      held <= 12'h000;
    end else if (!o_busy || o_pc != pc_q) begin
      held <= 12'h000;
    end else if (held != 12'hFFF) begin
      held <= held + 12'h001;
    end
  end
  a_exec_min: assert property (
    o_busy && $past(o_busy, 3) && o_pc != pc_q |-> held >= MIN_EXEC)
    else $error("program counter moved too early");
  a_tx_hold: assert property (
    o_tx_valid && !i_tx_ready |=> o_tx_valid)
    else $error("transmit valid dropped before acceptance");
  a_tx_data: assert property (
    o_tx_valid && !i_tx_ready |=> $stable(o_tx_data))
    else $error("transmit byte changed before acceptance");
  a_regs_idle: assert property (
    !o_busy && !i_start |=> $stable({o_acc, o_ptr, o_work}))
    else $error("register changed while idle");
  a_flags_idle: assert property (
    !o_busy && !i_start |=> $stable({o_carry, o_zero}))
    else $error("flag changed while idle");
  a_busy_start: assert property (
    !o_busy && i_start |-> ##[1:2] o_busy)
    else $error("start not taken");
  a_done_pulse: assert property (
    o_done |=> !o_done)
    else $error("done longer than one cycle");
  a_done_end: assert property (
    o_done |-> !o_busy && ($past(o_busy) || $past(o_busy, 2)))
    else $error("done without a finished program");
  c_run: cover property ($rose(o_busy));
  c_stall: cover property (o_tx_valid && !i_tx_ready);
  c_done: cover property (o_done);
endmodule : cps_sequencer_chk

bind cps_sequencer cps_sequencer_chk u_chk (
  .i_clock(i_clock),
  .i_rst_b(i_rst_b),
  .i_start(i_start),
  .i_tx_ready(i_tx_ready),
  .o_tx_valid(o_tx_valid),
  .o_tx_data(o_tx_data),
  .o_busy(o_busy),
  .o_done(o_done),
  .o_pc(o_pc),
  .o_acc(o_acc),
  .o_ptr(o_ptr),
  .o_work(o_work),
  .o_carry(o_carry),
  .o_zero(o_zero)
);

// File: hdl/cps_sequencer.sv
// Summary of operation
// RQ1: Add accumulator or pointer with selected operand
// RQ2: And accumulator or pointer with operand
// RQ3: Compare sets flags, operands unchanged
// RQ4: Add with carry, register and immediate forms
// RQ5: Branch by displacement when carry set
// RQ6: Branch by displacement when zero set
// RQ7: Subroutine saves return in byte 18
// RQ8: Rotate right through carry into bit seven
// RQ9: Send accumulator, parity and CRC variants
// RQ10: Receive line register, parity and CRC variants
// RQ11: Queue full test head minus 15 minus tail
// RQ12: Dequeue and enqueue with pointer increment
// RQ13: Table lookup copies or branches by offset
// RQ14: Program sets stack pointers before stack use
// RQ15: Stack return pops program counter twice-step
// RQ16: Extended tables shared across all channels
// RQ17: Address compare copies, subtracts, tests zero; code copies start bytes, clears work, sets zero
// RQ18: Char count steps address, range, CRC
// RQ19: Clear zeroes table byte or register
// RQ20: Load into accumulator or pointer
// RQ21: Store accumulator or pointer to table
// RQ22: Control table selected by channel number
// RQ23: Eight-bit registers, carry and zero flags

// ----------
// Transmit FIFO
// ----------
module cps_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign o_in_ready = (count != (AW + 1)'(DEPTH));
  assign push = i_in_valid && o_in_ready;
  assign pop = (count != '0) && (!o_out_valid || i_out_ready);

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_out_valid <= 1'b0;
      o_out_data <= '0;
    end else if (!o_out_valid || i_out_ready) begin
      o_out_valid <= (count != '0);
      if (count != '0) begin
        o_out_data <= mem[rd_ptr];
      end
    end
  end
endmodule : cps_fifo

// ----------
// Channel program sequencer
// ----------
module cps_sequencer #(
  parameter int CHANNELS = 4,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_prog_we,
  input wire logic [7:0] i_prog_addr,
  input wire logic [15:0] i_prog_data,
  input wire logic i_start,
  input wire logic [$clog2(CHANNELS)-1:0] i_channel,
  input wire logic [7:0] i_line_rx,
  input wire logic i_tx_ready,
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  output logic o_busy,
  output logic o_done,
  output logic [7:0] o_pc,
  output logic [7:0] o_acc,
  output logic [7:0] o_ptr,
  output logic [7:0] o_work,
  output logic o_carry,
  output logic o_zero,
  output logic o_rx_parity_err
);
  localparam int CHW = $clog2(CHANNELS);
  typedef enum logic [1:0] {
    S_IDLE = 2'b00, S_FETCH = 2'b01, S_EXEC = 2'b10
  } cps_state_t;

  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ cps_pkg::CRC_POLY) : (r << 1);
    end
    return r;
  endfunction : crc_step

  logic [15:0] prog [256];
  logic [7:0] ct [CHANNELS*64];
  logic [7:0] ext [256];
  logic [7:0] crc [CHANNELS];
  cps_state_t state;
  logic [15:0] instr;
  logic [CHW-1:0] chan;
  logic [cps_pkg::TIMER_W-1:0] timer;
  logic [7:0] rx_meta;
  logic [7:0] rx_line;
  logic fifo_ready;
  logic finish;
  cps_pkg::cps_class_t cls;
  logic [2:0] mode;
  logic [7:0] imm;
  logic [7:0] src;
  logic [8:0] sum;
  logic [7:0] next_acc, next_ptr, next_work, next_pc, next_crc;
  logic next_c, next_z, next_perr;
  logic ct_we0, ct_we1, ext_we, push, halt, search;
  logic [5:0] ct_wa0, ct_wa1;
  logic [7:0] ct_wd0, ct_wd1, ext_wa, ext_wd;
  logic [cps_pkg::TIMER_W-1:0] exec_cycles;

  function automatic logic [7:0] ctb(input logic [5:0] a);
    return ct[{chan, a}]; // [RQ22]
  endfunction : ctb

  assign cls = cps_pkg::cps_class_t'(instr[15:11]);
  assign mode = instr[10:8];
  assign imm = instr[7:0];
  assign search = ct[{chan, cps_pkg::CT_FLAGS}][0]; // [RQ13]
  assign finish = (state == S_EXEC) && (timer == 1)
    && !(cls == cps_pkg::OP_SEND && !fifo_ready);

  // ----------
  // Line register input synchroniser
  // ----------
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx_meta <= 8'h00;
      rx_line <= 8'h00;
    end else begin
      rx_meta <= i_line_rx;
      rx_line <= rx_meta;
    end
  end

  // ----------
  // Operand selection and execution
  // ----------
  always_comb begin
    unique case (mode)
      cps_pkg::M_R_LCT, cps_pkg::M_B_LCT: src = ctb(imm[5:0]);
      cps_pkg::M_R_IND: src = ctb(o_ptr[5:0]);
      cps_pkg::M_R_EXT: src = ext[ctb(imm[5:0]) + o_ptr]; // [RQ16]
      cps_pkg::M_B_FROM_R: src = o_acc;
      cps_pkg::M_R_FROM_B: src = o_ptr;
      default: src = imm;
    endcase
  end

  always_comb begin
    logic [7:0] dst;
    logic [7:0] t;
    logic to_b;
    t = 8'h00;
    to_b = (mode == cps_pkg::M_B_LCT) || (mode == cps_pkg::M_B_IMO);
    dst = to_b ? o_ptr : o_acc;
    next_acc = o_acc;
    next_ptr = o_ptr;
    next_work = o_work;
    next_c = o_carry;
    next_z = o_zero;
    next_pc = o_pc + 8'h01;
    next_crc = crc[chan];
    next_perr = o_rx_parity_err;
    ct_we0 = 1'b0;
    ct_wa0 = imm[5:0];
    ct_wd0 = 8'h00;
    ct_we1 = 1'b0;
    ct_wa1 = imm[5:0];
    ct_wd1 = 8'h00;
    ext_we = 1'b0;
    ext_wa = 8'h00;
    ext_wd = 8'h00;
    push = 1'b0;
    halt = 1'b0;
    sum = 9'h000;
    unique case (cls)
      cps_pkg::OP_ADD, cps_pkg::OP_ADDC: begin
        sum = {1'b0, dst} + {1'b0, src}
          + ((cls == cps_pkg::OP_ADDC) ? {8'h00, o_carry} : 9'h000); // [RQ1] [RQ4]
        next_c = sum[8];
        next_z = (sum[7:0] == 8'h00); // [RQ23]
        if (to_b) next_ptr = sum[7:0];
        else next_acc = sum[7:0];
      end
      cps_pkg::OP_AND: begin
        t = dst & src; // [RQ2]
        next_z = (t == 8'h00);
        if (to_b) next_ptr = t;
        else next_acc = t;
      end
      cps_pkg::OP_CMP: begin
        sum = {1'b0, dst} - {1'b0, src}; // [RQ3]
        next_c = sum[8];
        next_z = (sum[7:0] == 8'h00);
      end
      cps_pkg::OP_CLR: begin
        unique case (mode) // [RQ19]
          cps_pkg::M_R_IMO: next_acc = 8'h00;
          cps_pkg::M_B_IMO: next_ptr = 8'h00;
          cps_pkg::M_R_IND: begin
            ct_we0 = 1'b1;
            ct_wa0 = o_ptr[5:0];
          end
          default: ct_we0 = 1'b1;
        endcase
      end
      cps_pkg::OP_LD: begin
        if (mode == cps_pkg::M_B_LCT || mode == cps_pkg::M_B_IMO
            || mode == cps_pkg::M_B_FROM_R) next_ptr = src; // [RQ20]
        else next_acc = src;
      end
      cps_pkg::OP_ST: begin
        if (mode == cps_pkg::M_R_EXT) begin
          ext_we = 1'b1; // [RQ16] [RQ21]
          ext_wa = ctb(imm[5:0]) + o_ptr;
          ext_wd = o_acc;
        end else begin
          ct_we0 = 1'b1; // [RQ21]
          ct_wa0 = (mode == cps_pkg::M_R_IND) ? o_ptr[5:0] : imm[5:0];
          ct_wd0 = (mode == cps_pkg::M_B_LCT) ? o_ptr : o_acc;
        end
      end
      cps_pkg::OP_ROTR: begin
        t = (dst >> 1) | (o_carry ? cps_pkg::MSB_WEIGHT : 8'h00); // [RQ8]
        next_c = dst[0];
        if (mode == cps_pkg::M_B_IMO) next_ptr = t;
        else next_acc = t;
      end
      cps_pkg::OP_BCT: if (o_carry) next_pc = o_pc + imm; // [RQ5]
      cps_pkg::OP_BZT: if (o_zero) next_pc = o_pc + imm; // [RQ6]
      cps_pkg::OP_BS: begin
        ct_we0 = 1'b1; // [RQ7]
        ct_wa0 = cps_pkg::CT_RETURN;
        ct_wd0 = o_pc + 8'h01;
        next_pc = o_pc + imm;
      end
      cps_pkg::OP_RETURN_FROM_SUBROUTINE: next_pc = ctb(cps_pkg::CT_RETURN); // [RQ7]
      cps_pkg::OP_RETU: begin
        t = ctb(cps_pkg::CT_STACK) + 8'h01; // [RQ15] [RQ14]
        next_pc = ctb(t[5:0]);
        ct_we0 = 1'b1;
        ct_wa0 = cps_pkg::CT_STACK;
        ct_wd0 = t + 8'h01;
      end
      cps_pkg::OP_SEND: begin
        push = 1'b1; // [RQ9]
        if (mode[1]) next_crc = crc_step(crc[chan], o_acc);
      end
      cps_pkg::OP_RECEIVE_CHAR: begin
        t = rx_line; // [RQ10]
        if (mode[0]) begin
          next_perr = ^t;
          t[7] = 1'b0;
        end
        next_acc = t;
        if (mode[1]) next_crc = crc_step(crc[chan], t);
      end
      cps_pkg::OP_QFULL: begin
        sum = {1'b0, ctb(cps_pkg::CT_QHEAD)} - {1'b0, cps_pkg::QFULL_BIAS}
          - {1'b0, ctb(cps_pkg::CT_QTAIL)}; // [RQ11]
        next_work = sum[7:0];
        next_c = sum[8];
        next_z = (sum[7:0] == 8'h00);
      end
      cps_pkg::OP_DEQ: begin
        t = ctb(cps_pkg::CT_QHEAD); // [RQ12]
        next_acc = ctb(t[5:0]);
        ct_we0 = 1'b1;
        ct_wa0 = cps_pkg::CT_QHEAD;
        ct_wd0 = t + 8'h01;
      end
      cps_pkg::OP_ENQ: begin
        t = ctb(cps_pkg::CT_QTAIL); // [RQ12]
        ct_we0 = 1'b1;
        ct_wa0 = t[5:0];
        ct_wd0 = o_acc;
        ct_we1 = 1'b1;
        ct_wa1 = cps_pkg::CT_QTAIL;
        ct_wd1 = t + 8'h01;
      end
      cps_pkg::OP_TLU: begin
        t = ext[ctb(imm[5:0]) + o_acc]; // [RQ13]
        if (!search) begin
          next_acc = t;
          next_work = t;
          next_pc = o_pc + cps_pkg::TLU_SKIP;
        end else begin
          t = (t & cps_pkg::TLU_MASK) << 1;
          next_work = t;
          next_pc = o_pc + cps_pkg::TLU_BIAS + t;
        end
      end
      cps_pkg::OP_ADDRESS_RANGE_COMPARE: begin
        ct_we0 = 1'b1; // [RQ17]
        ct_wa0 = cps_pkg::CT_CUR_ADDR;
        ct_wd0 = ctb(cps_pkg::CT_INIT_ADDR);
        ct_we1 = 1'b1;
        ct_wa1 = cps_pkg::CT_CUR_RANGE;
        ct_wd1 = ctb(cps_pkg::CT_INIT_RANGE);
        next_work = 8'h00;
        next_z = 1'b1;
      end
      cps_pkg::OP_CCH: begin
        ct_we0 = 1'b1; // [RQ18]
        ct_wa0 = cps_pkg::CT_CUR_ADDR;
        ct_wd0 = ctb(cps_pkg::CT_CUR_ADDR) - 8'h01;
        ct_we1 = 1'b1;
        ct_wa1 = cps_pkg::CT_CUR_RANGE;
        ct_wd1 = ctb(cps_pkg::CT_CUR_RANGE) + 8'h01;
        next_crc = crc_step(crc[chan], o_acc);
      end
      cps_pkg::OP_HALT: begin
        halt = 1'b1;
        next_pc = o_pc;
      end
      default: halt = 1'b1;
    endcase
  end

  // ----------
  // Execution time of the fetched instruction
  // ----------
  always_comb begin
    logic [15:0] w;
    int ns;
    w = prog[o_pc];
    ns = cps_pkg::T_BASIC_NS;
    unique case (w[15:11])
      cps_pkg::OP_ADDC: ns = (w[10:8] == cps_pkg::M_R_IND) ? cps_pkg::T_ADDC_B_NS
        : (w[10:8] >= cps_pkg::M_R_IMO) ? cps_pkg::T_ADDC_IMO_NS : cps_pkg::T_ADDC_NS;
      cps_pkg::OP_LD: if (w[10:8] == cps_pkg::M_R_EXT) ns = cps_pkg::T_LD_EXT_NS;
      cps_pkg::OP_ST: if (w[10:8] == cps_pkg::M_R_EXT) ns = cps_pkg::T_ST_EXT_NS;
      cps_pkg::OP_ROTR: ns = cps_pkg::T_ROT_NS;
      cps_pkg::OP_BCT: if (o_carry) ns = cps_pkg::T_TAKEN_NS;
      cps_pkg::OP_BZT: if (o_zero) ns = cps_pkg::T_TAKEN_NS;
      cps_pkg::OP_BS: ns = cps_pkg::T_BS_NS;
      cps_pkg::OP_RETURN_FROM_SUBROUTINE: ns = cps_pkg::T_RETURN_FROM_SUBROUTINE_NS;
      cps_pkg::OP_RETU: ns = cps_pkg::T_RETU_NS;
      cps_pkg::OP_SEND: ns = w[9] ? (w[8] ? cps_pkg::T_SEND3_NS : cps_pkg::T_SEND2_NS)
        : (w[8] ? cps_pkg::T_SEND1_NS : cps_pkg::T_SEND0_NS);
      cps_pkg::OP_RECEIVE_CHAR: ns = w[9] ? (w[8] ? cps_pkg::T_RECV3_NS : cps_pkg::T_RECV2_NS)
        : (w[8] ? cps_pkg::T_RECV1_NS : cps_pkg::T_RECV0_NS);
      cps_pkg::OP_QFULL: ns = cps_pkg::T_QFULL_NS;
      cps_pkg::OP_DEQ, cps_pkg::OP_ENQ: ns = cps_pkg::T_QUEUE_NS;
      cps_pkg::OP_TLU: ns = search ? cps_pkg::T_TLU_SRCH_NS
        : cps_pkg::T_TLU_HIT_NS;
      cps_pkg::OP_ADDRESS_RANGE_COMPARE: ns = cps_pkg::T_ADDRESS_RANGE_COMPARE_NS;
      cps_pkg::OP_CCH: ns = cps_pkg::T_CCH_NS;
      default: ns = cps_pkg::T_BASIC_NS;
    endcase
    exec_cycles = cps_pkg::TIMER_W'(cps_pkg::cps_cycles(ns));
  end

  // ----------
  // Memories
  // ----------
  always_ff @(posedge i_clock) begin
    if (i_prog_we) prog[i_prog_addr] <= i_prog_data;
    if (finish && ct_we0) ct[{chan, ct_wa0}] <= ct_wd0; // [RQ22]
    if (finish && ct_we1) ct[{chan, ct_wa1}] <= ct_wd1;
    if (finish && ext_we) ext[ext_wa] <= ext_wd;
    if (finish) crc[chan] <= next_crc;
  end

  // ----------
  // Sequencer state
  // ----------
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= S_IDLE;
      instr <= 16'h0000;
      chan <= '0;
      timer <= '0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_pc <= 8'h00;
    end else begin
      o_done <= 1'b0;
      unique case (state)
        S_IDLE: if (i_start) begin
          chan <= i_channel;
          o_pc <= 8'h00;
          o_busy <= 1'b1;
          state <= S_FETCH;
        end
        S_FETCH: begin
          instr <= prog[o_pc];
          timer <= exec_cycles;
          state <= S_EXEC;
        end
        S_EXEC: if (finish) begin
          o_pc <= next_pc;
          if (halt) begin
            o_busy <= 1'b0;
            o_done <= 1'b1;
            state <= S_IDLE;
          end else begin
            state <= S_FETCH;
          end
        end else if (timer != 1) begin
          timer <= timer - 1'b1;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_acc <= 8'h00;
      o_ptr <= 8'h00;
      o_work <= 8'h00;
      o_carry <= 1'b0;
      o_zero <= 1'b0;
      o_rx_parity_err <= 1'b0;
    end else if (finish) begin
      o_acc <= next_acc;
      o_ptr <= next_ptr;
      o_work <= next_work;
      o_carry <= next_c;
      o_zero <= next_z;
      o_rx_parity_err <= next_perr;
    end
  end

  // ----------
  // Transmit path
  // ----------
  cps_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_in_valid(finish && push),
    .o_in_ready(fifo_ready),
    .i_in_data(instr[8] ? {^o_acc[6:0], o_acc[6:0]} : o_acc), // [RQ9]
    .o_out_valid(o_tx_valid),
    .i_out_ready(i_tx_ready),
    .o_out_data(o_tx_data)
  );
endmodule : cps_sequencer
